// ---- design/pifb_bank.v ----
// Peripheral interrupt enable and request flag bank with an APB slave.
// What this block does
// - Enable two holds osc fail, cmp two, cmp one, eeprom, collision, wake, capcmp two.
// - Unimplemented bits of enable two, request two and request one read zero.
// - Flags set on their event regardless of enables or global enable.
// - Converter done flag, request one bit 6, sets on conversion end, sticky.
// - Receive full flag, bit 5, read only, follows buffer, cleared by data read.
// - Transmit empty flag, bit 4, read only, cleared by transmit data write.
// - Serial port flag, bit 3, sets on SPI or I2C transfer completion.
// - Serial port flag also sets when master-initiated I2C sequences complete.
// - Serial port flag sets on bus start or stop seen while idle.
// - Capcmp one flag, bit 2, sets on capture or compare, software cleared.
// - Timer two flag, bit 1, sets on period match, software cleared.
// - Timer one flag, bit 0, sets on count overflow, software cleared.
// - Osc fail flag, request two bit 7, sets on oscillator failure.
// - Comparator flags, bits 6 and 5, set on comparator output change.
// - Eeprom write flag, bit 4, sets when a data write completes.
// - Bus collision flag, bit 3, sets on I2C master collision.
// - Wake flag, bit 2, sets on wake-up condition, software cleared.
// - Capcmp two flag, bit 0, sets on capture or compare, software cleared.
// - Peripheral requests reach the core only with group enable set.
// - Global enable gates every unmasked interrupt.
// - Enable one mirrors request one bit positions.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`include "pifb_defines.vh"
module pifb_bank #(
  parameter RX_W = 8
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        adc_done,
  input  wire        rx_push,
  input  wire [RX_W-1:0] rx_byte,
  input  wire        tx_pop,
  input  wire        ssp_xfer_done,
  input  wire        ssp_seq_done,
  input  wire        ssp_bus_event_idle,
  input  wire        capcmp_one_event,
  input  wire        timer_two_match,
  input  wire        timer_one_overflow,
  input  wire        osc_failed,
  input  wire        cmp_two_output,
  input  wire        cmp_one_output,
  input  wire        eeprom_write_done,
  input  wire        bus_collision,
  input  wire        lowpower_wake,
  input  wire        capcmp_two_event,
  output reg         periph_irq,
  output reg         tx_write_strobe,
  output reg  [7:0]  tx_write_data
);
  // Core control, enables and flag state.
  reg [7:0]      core_irq_control_r;
  reg [7:0]      peripheral_irq_enable_one_r;
  reg [7:0]      peripheral_irq_enable_two_r;
  reg [7:0]      sw_flags_one_r;
  reg [7:0]      peripheral_irq_request_two_r;
  reg            rx_full_flag_r;
  reg            tx_empty_flag_r;
  reg [RX_W-1:0] rx_data_register_r;
  reg            cmp_two_prev_r;
  reg            cmp_one_prev_r;
  reg            osc_prev_r;
  wire [1:0]     cmp_sync;
  wire           osc_sync;
  wire [7:0]     set_one;
  wire [7:0]     set_two;
  wire [7:0]     request_one;
  wire           bus_wr;
  wire           bus_rd;
  wire           osc_rise;
  reg  [31:0]    rd_nxt;
  reg            err_nxt;
  wire           irq_nxt;

  // Decodes whether an address lands on a mapped register.
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `PIFB_OFF_CORE_CTRL)   || (a == `PIFB_OFF_ENABLE_ONE) ||
               (a == `PIFB_OFF_ENABLE_TWO)  || (a == `PIFB_OFF_REQUEST_ONE) ||
               (a == `PIFB_OFF_REQUEST_TWO) || (a == `PIFB_OFF_RX_DATA) ||
               (a == `PIFB_OFF_TX_DATA)     || (a == `PIFB_OFF_STATUS);
    end
  endfunction

  // Comparator outputs and the oscillator fail level come from other domains.
  pifb_sync #(.W(3)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       ({osc_failed, cmp_two_output, cmp_one_output}),
    .q       ({osc_sync, cmp_sync})
  );

  assign bus_wr = psel & penable & pwrite & ce & pready;
  assign bus_rd = psel & penable & ~pwrite & ce & pready;
  assign osc_rise = osc_sync & ~osc_prev_r;

  // Event set vectors, independent of any enable.
  assign set_one = {1'b0,
                    adc_done,
                    1'b0,
                    1'b0,
                    ssp_xfer_done | ssp_seq_done | ssp_bus_event_idle,
                    capcmp_one_event,
                    timer_two_match,
                    timer_one_overflow};
  assign set_two = {osc_rise,
                    cmp_sync[1] ^ cmp_two_prev_r,
                    cmp_sync[0] ^ cmp_one_prev_r,
                    eeprom_write_done,
                    bus_collision,
                    lowpower_wake,
                    1'b0,
                    capcmp_two_event};

  assign request_one = (sw_flags_one_r & `PIFB_SW_MASK_ONE) |
                       {2'b00, rx_full_flag_r, tx_empty_flag_r, 4'h0};

  // Sources OR'd through their enables, then group and global gates.
  assign irq_nxt = core_irq_control_r[`PIFB_BIT_GLOBAL_EN] &
                   core_irq_control_r[`PIFB_BIT_GROUP_EN] &
                   (|(request_one & peripheral_irq_enable_one_r) |
                    |(peripheral_irq_request_two_r &
                      peripheral_irq_enable_two_r));

  // Read mux and error answer for unmapped addresses.
  always @* begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = ~mapped(paddr);
    case (paddr)
      `PIFB_OFF_CORE_CTRL:   rd_nxt[7:0] = core_irq_control_r;
      `PIFB_OFF_ENABLE_ONE:  rd_nxt[7:0] = peripheral_irq_enable_one_r;
      `PIFB_OFF_ENABLE_TWO:  rd_nxt[7:0] = peripheral_irq_enable_two_r;
      `PIFB_OFF_REQUEST_ONE: rd_nxt[7:0] = request_one;
      `PIFB_OFF_REQUEST_TWO: rd_nxt[7:0] = peripheral_irq_request_two_r;
      `PIFB_OFF_RX_DATA:     rd_nxt[RX_W-1:0] = rx_data_register_r;
      `PIFB_OFF_STATUS:      rd_nxt[0] = periph_irq;
      default:               rd_nxt = 32'h0000_0000;
    endcase
  end

  // APB handshake: one wait state, pready high in the second access cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        pslverr <= err_nxt;
        prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
      end
    end
  end

  // Control and enable registers written by software.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_irq_control_r          <= `PIFB_RST_CTRL;
      peripheral_irq_enable_one_r <= `PIFB_RST_ENABLE;
      peripheral_irq_enable_two_r <= `PIFB_RST_ENABLE;
    end else if (ce && bus_wr && mapped(paddr)) begin
      if (paddr == `PIFB_OFF_CORE_CTRL) begin
        core_irq_control_r <= pwdata[7:0] & 8'hc0;
      end
      if (paddr == `PIFB_OFF_ENABLE_ONE) begin
        peripheral_irq_enable_one_r <= pwdata[7:0] & `PIFB_MASK_ONE;
      end
      if (paddr == `PIFB_OFF_ENABLE_TWO) begin
        peripheral_irq_enable_two_r <= pwdata[7:0] & `PIFB_MASK_TWO;
      end
    end
  end

  // Sticky flags: a software write stores, an event in the same cycle wins.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_flags_one_r               <= `PIFB_RST_REQUEST;
      peripheral_irq_request_two_r <= `PIFB_RST_REQUEST;
      cmp_two_prev_r               <= 1'b0;
      cmp_one_prev_r               <= 1'b0;
      osc_prev_r                   <= 1'b0;
    end else if (ce) begin
      cmp_two_prev_r <= cmp_sync[1];
      cmp_one_prev_r <= cmp_sync[0];
      osc_prev_r     <= osc_sync;
      if (bus_wr && paddr == `PIFB_OFF_REQUEST_ONE) begin
        sw_flags_one_r <= (pwdata[7:0] | set_one) & `PIFB_SW_MASK_ONE;
      end else begin
        sw_flags_one_r <= (sw_flags_one_r | set_one) & `PIFB_SW_MASK_ONE;
      end
      if (bus_wr && paddr == `PIFB_OFF_REQUEST_TWO) begin
        peripheral_irq_request_two_r <= (pwdata[7:0] | set_two) &
                                        `PIFB_MASK_TWO;
      end else begin
        peripheral_irq_request_two_r <= (peripheral_irq_request_two_r |
                                         set_two) & `PIFB_MASK_TWO;
      end
    end
  end

  // Receive buffer: push sets full, data read clears, push wins.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_full_flag_r     <= 1'b0;
      rx_data_register_r <= {RX_W{1'b0}};
    end else if (ce) begin
      if (rx_push) begin
        rx_full_flag_r     <= 1'b1;
        rx_data_register_r <= rx_byte;
      end else if (bus_rd && paddr == `PIFB_OFF_RX_DATA) begin
        rx_full_flag_r <= 1'b0;
      end
    end
  end

  // Transmit buffer: empty after reset, write fills, transmitter pop empties.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_empty_flag_r <= 1'b1;
      tx_write_strobe <= 1'b0;
      tx_write_data   <= 8'h00;
    end else if (ce) begin
      tx_write_strobe <= 1'b0;
      if (tx_pop) begin
        tx_empty_flag_r <= 1'b1;
      end else if (bus_wr && paddr == `PIFB_OFF_TX_DATA) begin
        tx_empty_flag_r <= 1'b0;
      end
      if (bus_wr && paddr == `PIFB_OFF_TX_DATA) begin
        tx_write_strobe <= 1'b1;
        tx_write_data   <= pwdata[7:0];
      end
    end
  end

  // Registered interrupt request output.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_irq <= 1'b0;
    end else if (ce) begin
      periph_irq <= irq_nxt;
    end
  end
endmodule // pifb_bank

// ---- common/pifb_defines.vh ----
// Register offsets, field positions and reset values of the flag bank.
`ifndef PIFB_DEFINES_VH
`define PIFB_DEFINES_VH
`define PIFB_OFF_CORE_CTRL   12'h000
`define PIFB_OFF_ENABLE_ONE  12'h004
`define PIFB_OFF_ENABLE_TWO  12'h008
`define PIFB_OFF_REQUEST_ONE 12'h00c
`define PIFB_OFF_REQUEST_TWO 12'h010
`define PIFB_OFF_RX_DATA     12'h014
`define PIFB_OFF_TX_DATA     12'h018
`define PIFB_OFF_STATUS      12'h01c
`define PIFB_BIT_GLOBAL_EN   7
`define PIFB_BIT_GROUP_EN    6
`define PIFB_MASK_ONE        8'h7f
`define PIFB_MASK_TWO        8'hfd
`define PIFB_SW_MASK_ONE     8'h4f
`define PIFB_RST_CTRL        8'h00
`define PIFB_RST_ENABLE      8'h00
`define PIFB_RST_REQUEST     8'h00
`define PIFB_RST_RX_DATA     8'h00
`endif

// ---- design/pifb_sync.v ----
// Three-stage synchroniser with agreement of the last two stages.
module pifb_sync #(
  parameter W = 8
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         ce,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer     i;

  // Stage one feeds only stage two; output follows where two and three agree.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else if (ce) begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          q[i] <= s3_r[i];
        end
      end
    end
  end
endmodule // pifb_sync

// ---- sim/pifb_bank_assertions.sv ----
// Checker of the flag bank's APB answer, read masks and interrupt gate.
`include "pifb_defines.vh"
module pifb_bank_assertions (
  input logic        pclk,
  input logic        presetn,
  input logic        ce,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        periph_irq,
  input logic        tx_write_strobe
);
  logic gate_r;
  wire  rd_done = pready && !pwrite;
  // Shadow of both core gate bits, taken when a control write completes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gate_r <= 1'b0;
    else if (pready && pwrite && paddr == `PIFB_OFF_CORE_CTRL)
      gate_r <= pwdata[7] & pwdata[6];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_one_wait: assert property (psel && penable && !pready && ce
    |=> pready) else $error("pready not one cycle after access");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (pready && paddr > 12'h01c |-> pslverr)
    else $error("unmapped access not refused");
  a_upper_zero: assert property (rd_done |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_req_one_hole: assert property (
    rd_done && paddr == `PIFB_OFF_REQUEST_ONE |-> !prdata[7])
    else $error("request one bit 7 not zero");
  a_two_hole: assert property (
    rd_done && (paddr == `PIFB_OFF_REQUEST_TWO ||
    paddr == `PIFB_OFF_ENABLE_TWO) |-> !prdata[1])
    else $error("bit 1 of a second register not zero");
  a_irq_gated: assert property (!gate_r && !$past(gate_r) |-> !periph_irq)
    else $error("interrupt raised while gated off");
  a_tx_strobe: assert property (pready && pwrite && ce &&
    paddr == `PIFB_OFF_TX_DATA |-> ##[0:1] tx_write_strobe)
    else $error("transmit write gave no strobe");
endmodule // pifb_bank_assertions

// ---- sim/pifb_periph_model.sv ----
// Peripheral event source model driving the flag bank's event inputs.
module pifb_periph_model #(
  parameter logic [7:0] RX_VALUE = 8'ha5
) (
  input  logic        pclk,
  input  logic        presetn,
  input  logic [15:0] fire,
  output logic [13:0] ev,
  output logic        rx_push,
  output logic [7:0]  rx_byte,
  output logic        tx_pop
);
  // Events pulse one cycle; oscillator and comparators toggle as levels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev <= 14'h0;
      rx_push <= 1'b0;
      tx_pop <= 1'b0;
    end else begin
      ev <= (fire[13:0] & ~14'h0380) | ((ev ^ fire[13:0]) & 14'h0380);
      rx_push <= fire[14];
      tx_pop <= fire[15];
    end
  end
  // Receive byte is only valid with its push; otherwise it is inverted.
  assign rx_byte = rx_push ? RX_VALUE : ~RX_VALUE;
endmodule // pifb_periph_model

// ---- sim/pifb_bank_test.sv ----
// Self-checking bench of the flag bank over APB with a peripheral model.
`include "pifb_defines.vh"
module pifb_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic        periph_irq, tx_write_strobe, rx_push, tx_pop;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0]  tx_write_data, tx_seen, rx_byte;
  logic [15:0] fire;
  logic [13:0] ev;
  int          fail_count, cmp_count, cyc;
  localparam logic [15:0] EXP [0:13] = '{16'h0040, 16'h0008, 16'h0008,
    16'h0008, 16'h0004, 16'h0002, 16'h0001, 16'h8000, 16'h4000, 16'h2000,
    16'h1000, 16'h0800, 16'h0400, 16'h0100};
  pifb_bank #(.RX_W(8)) pifb_bank_i (.pclk(pclk), .presetn(presetn),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_done(ev[0]), .rx_push(rx_push),
    .rx_byte(rx_byte), .tx_pop(tx_pop), .ssp_xfer_done(ev[1]),
    .ssp_seq_done(ev[2]), .ssp_bus_event_idle(ev[3]),
    .capcmp_one_event(ev[4]), .timer_two_match(ev[5]),
    .timer_one_overflow(ev[6]), .osc_failed(ev[7]), .cmp_two_output(ev[8]),
    .cmp_one_output(ev[9]), .eeprom_write_done(ev[10]),
    .bus_collision(ev[11]), .lowpower_wake(ev[12]),
    .capcmp_two_event(ev[13]), .periph_irq(periph_irq),
    .tx_write_strobe(tx_write_strobe), .tx_write_data(tx_write_data));
  pifb_periph_model pifb_periph_model_i (.pclk(pclk), .presetn(presetn),
    .fire(fire), .ev(ev), .rx_push(rx_push), .rx_byte(rx_byte),
    .tx_pop(tx_pop));
  // Clock generation.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Capture of each byte handed to the transmitter.
  always @(posedge pclk) if (tx_write_strobe === 1'b1) tx_seen <= tx_write_data;
  // Cycle ceiling against a hang.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // One APB transfer: setup, access until pready, release, one idle edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) fail_count++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("read %h", a), e, rdat);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic kick(input int i);
    fire <= 16'h1 << i;
    @(posedge pclk);
    fire <= 16'h0;
    repeat (6) @(posedge pclk);
  endtask
  // Main sequence.
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, fire, tx_seen} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`PIFB_OFF_CORE_CTRL, 32'h0);
    rd(`PIFB_OFF_ENABLE_ONE, 32'h0);
    rd(`PIFB_OFF_REQUEST_ONE, 32'h10);
    rd(`PIFB_OFF_REQUEST_TWO, 32'h0);
    wr(`PIFB_OFF_ENABLE_ONE, 32'hffffffff);
    rd(`PIFB_OFF_ENABLE_ONE, 32'h7f);
    wr(`PIFB_OFF_ENABLE_TWO, 32'hffffffff);
    rd(`PIFB_OFF_ENABLE_TWO, 32'hfd);
    wr(`PIFB_OFF_CORE_CTRL, 32'hff);
    rd(`PIFB_OFF_CORE_CTRL, 32'hc0);
    wr(`PIFB_OFF_CORE_CTRL, 32'h0);
    rd(12'h100, 32'h0);
    chk("slverr", 32'h1, {31'h0, rerr});
    for (int i = 0; i < 14; i++) begin
      wr(`PIFB_OFF_REQUEST_ONE, 32'h0);
      wr(`PIFB_OFF_REQUEST_TWO, 32'h0);
      kick(i);
      rd(`PIFB_OFF_REQUEST_ONE, {24'h0, EXP[i][7:0] | 8'h10});
      rd(`PIFB_OFF_REQUEST_TWO, {24'h0, EXP[i][15:8]});
      chk("irq", 32'h0, {31'h0, periph_irq});
    end
    kick(14);
    rd(`PIFB_OFF_REQUEST_ONE, 32'h30);
    rd(`PIFB_OFF_RX_DATA, 32'ha5);
    rd(`PIFB_OFF_REQUEST_ONE, 32'h10);
    wr(`PIFB_OFF_TX_DATA, 32'h3c);
    rd(`PIFB_OFF_REQUEST_ONE, 32'h0);
    chk("tx byte", 32'h3c, {24'h0, tx_seen});
    kick(15);
    rd(`PIFB_OFF_REQUEST_ONE, 32'h10);
    wr(`PIFB_OFF_REQUEST_ONE, 32'h0);
    wr(`PIFB_OFF_REQUEST_TWO, 32'h0);
    wr(`PIFB_OFF_ENABLE_ONE, 32'h1);
    wr(`PIFB_OFF_ENABLE_TWO, 32'h0);
    wr(`PIFB_OFF_CORE_CTRL, 32'hc0);
    rd(`PIFB_OFF_STATUS, 32'h0);
    kick(6);
    chk("irq", 32'h1, {31'h0, periph_irq});
    wr(`PIFB_OFF_CORE_CTRL, 32'h80);
    @(posedge pclk);
    chk("irq", 32'h0, {31'h0, periph_irq});
    wr(`PIFB_OFF_CORE_CTRL, 32'hc0);
    @(posedge pclk);
    chk("irq", 32'h1, {31'h0, periph_irq});
    wr(`PIFB_OFF_REQUEST_ONE, 32'h0);
    @(posedge pclk);
    chk("irq", 32'h0, {31'h0, periph_irq});
    summarize();
  end
endmodule // pifb_bank_test
bind pifb_bank pifb_bank_assertions pifb_bank_assertions_i (.pclk(pclk),
  .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .periph_irq(periph_irq),
  .tx_write_strobe(tx_write_strobe));
